/* core/period_timer.sv */
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "period_timer_map.svh"
module period_timer (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic sleep,
    output logic pwm_time_base,
    output logic spi_shift_clk,
    output logic irq
);

    period_timer_pkg::timer_control_t ctl_r;
    period_timer_pkg::bus_state_t bus_r;
    period_timer_pkg::bus_state_t bus_nxt;
    logic [7:0] tmr_r;
    logic [7:0] pr_r;
    logic [1:0] instr_cnt_r;
    logic [5:0] pre_r;
    logic [3:0] post_r;
    logic match_r;
    logic flag_r;
    logic en_r;
    logic [31:0] readdata_r;
    logic instr_ce;
    logic active;
    logic pre_tick;
    logic match_ev;
    logic wr_go;
    logic rd_go;
    logic wr_lane0;
    logic wr_tmr;
    logic wr_pr;
    logic wr_ctl;
    logic wr_sts;
    logic wr_msk;
    logic [7:0] rd_mux;

    function automatic logic [5:0] pre_last(input logic [1:0] sel);
        case (sel)
            2'h0: pre_last = `PT_PRE_LAST_DIV1;
            2'h1: pre_last = `PT_PRE_LAST_DIV4;
            2'h2: pre_last = `PT_PRE_LAST_DIV16;
            default: pre_last = `PT_PRE_LAST_DIV64;
        endcase
    endfunction

    function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
        hit = (addr == ofs);
    endfunction

    // Avalon slave: one wait cycle, answer in the second cycle
    always_comb begin
        case (bus_r)
            period_timer_pkg::BUS_IDLE: begin
                if (read || write) begin
                    bus_nxt = period_timer_pkg::BUS_ACK;
                end else begin
                    bus_nxt = period_timer_pkg::BUS_IDLE;
                end
            end
            default: bus_nxt = period_timer_pkg::BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            bus_r <= period_timer_pkg::BUS_IDLE;
        end else begin
            bus_r <= bus_nxt;
        end
    end

    assign waitrequest = (read || write) && (bus_r != period_timer_pkg::BUS_ACK);
    assign wr_go = write && (bus_r == period_timer_pkg::BUS_ACK);
    assign rd_go = read && (bus_r == period_timer_pkg::BUS_IDLE);
    assign wr_lane0 = wr_go && byteenable[0];

    always_comb begin
        wr_tmr = 1'b0;
        wr_pr = 1'b0;
        wr_ctl = 1'b0;
        wr_sts = 1'b0;
        wr_msk = 1'b0;
        if (hit(address, 5'(`PT_OFS_TICK_COUNTER))) begin
            wr_tmr = wr_lane0;
        end else if (hit(address, 5'(`PT_OFS_PERIOD_VALUE))) begin
            wr_pr = wr_lane0;
        end else if (hit(address, 5'(`PT_OFS_TIMER_CONTROL))) begin
            wr_ctl = wr_lane0;
        end else if (hit(address, 5'(`PT_OFS_IRQ_STATUS))) begin
            wr_sts = wr_lane0;
        end else if (hit(address, 5'(`PT_OFS_IRQ_MASK))) begin
            wr_msk = wr_lane0;
        end
    end

    always_comb begin
        if (hit(address, 5'(`PT_OFS_TICK_COUNTER))) begin
            rd_mux = tmr_r;
        end else if (hit(address, 5'(`PT_OFS_PERIOD_VALUE))) begin
            rd_mux = pr_r;
        end else if (hit(address, 5'(`PT_OFS_TIMER_CONTROL))) begin
            rd_mux = {1'b0, ctl_r};
        end else if (hit(address, 5'(`PT_OFS_IRQ_STATUS))) begin
            rd_mux = {7'h00, flag_r};
        end else if (hit(address, 5'(`PT_OFS_IRQ_MASK))) begin
            rd_mux = {7'h00, en_r};
        end else begin
            rd_mux = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            readdata_r <= 32'h00000000;
        end else if (rd_go) begin
            readdata_r <= {24'h000000, rd_mux};
        end
    end

    assign readdata = readdata_r;

    // Instruction clock enable, one clk in four
    always_ff @(posedge clk) begin
        if (!nrst) begin
            instr_cnt_r <= 2'h0;
        end else begin
            instr_cnt_r <= instr_cnt_r + 2'h1;
        end
    end

    assign instr_ce = (instr_cnt_r == `PT_INSTR_DIV_LAST);
    assign active = instr_ce && ctl_r.run_enable && !sleep;
    assign pre_tick = active && (pre_r == pre_last(ctl_r.prescale_select));
    assign match_ev = pre_tick && (tmr_r == pr_r);

    // Prescaler
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pre_r <= 6'h00;
        end else if (wr_tmr || wr_ctl) begin
            pre_r <= 6'h00;
        end else if (pre_tick) begin
            pre_r <= 6'h00;
        end else if (active) begin
            pre_r <= pre_r + 6'h01;
        end
    end

    // Counter
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tmr_r <= `PT_RST_TICK_COUNTER;
        end else if (wr_tmr) begin
            tmr_r <= writedata[7:0];
        end else if (match_ev) begin
            tmr_r <= 8'h00;
        end else if (pre_tick) begin
            tmr_r <= tmr_r + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pr_r <= `PT_RST_PERIOD_VALUE;
        end else if (wr_pr) begin
            pr_r <= writedata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctl_r <= `PT_RST_TIMER_CONTROL;
        end else if (wr_ctl) begin
            ctl_r <= writedata[6:0];
        end
    end

    // Unscaled match pulse
    always_ff @(posedge clk) begin
        if (!nrst) begin
            match_r <= 1'b0;
        end else begin
            match_r <= match_ev;
        end
    end

    assign pwm_time_base = match_r;
    assign spi_shift_clk = match_r;

    // Postscaler
    always_ff @(posedge clk) begin
        if (!nrst) begin
            post_r <= 4'h0;
        end else if (wr_tmr || wr_ctl) begin
            post_r <= 4'h0;
        end else if (match_ev && post_r == ctl_r.postscale_select) begin
            post_r <= 4'h0;
        end else if (match_ev) begin
            post_r <= post_r + 4'h1;
        end
    end

    // Sticky flag, set wins over write-one clear
    always_ff @(posedge clk) begin
        if (!nrst) begin
            flag_r <= 1'b0;
        end else if (match_ev && post_r == ctl_r.postscale_select && !wr_ctl && !wr_tmr) begin
            flag_r <= 1'b1;
        end else if (wr_sts && writedata[`PT_IRQ_MATCH_BIT]) begin
            flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            en_r <= 1'b0;
        end else if (wr_msk) begin
            en_r <= writedata[`PT_IRQ_MATCH_BIT];
        end
    end

    assign irq = flag_r && en_r;

    property p_instr_rate;
        @(posedge clk) disable iff (!nrst)
        instr_ce |=> !instr_ce [*3] ##1 instr_ce;
    endproperty
    a_instr_rate: assert property (p_instr_rate)
        else $error("instruction enable not one in four");

    property p_count_step;
        @(posedge clk) disable iff (!nrst)
        ($past(nrst) && !$past(wr_tmr) && !$past(match_ev) && tmr_r != $past(tmr_r))
            |-> $past(pre_tick) && tmr_r == $past(tmr_r) + 8'h01;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter moved without a prescaled tick");

    property p_prescale_gap;
        @(posedge clk) disable iff (!nrst)
        (pre_tick && ctl_r.prescale_select == 2'h1 && !sleep)
            ##1 (!wr_ctl && !wr_tmr && !sleep && ctl_r.run_enable) [*8]
            |-> !pre_tick;
    endproperty
    a_prescale_gap: assert property (p_prescale_gap)
        else $error("divide by four ticked too early");

    property p_match_cause;
        @(posedge clk) disable iff (!nrst)
        match_r |-> $past(tmr_r == pr_r) && $past(pre_tick);
    endproperty
    a_match_cause: assert property (p_match_cause)
        else $error("match without equal count");

    property p_match_zero;
        @(posedge clk) disable iff (!nrst)
        (match_r && !$past(wr_tmr)) |-> tmr_r == 8'h00;
    endproperty
    a_match_zero: assert property (p_match_zero)
        else $error("counter not zero after match");

    property p_reset_vals;
        @(posedge clk)
        (nrst && !$past(nrst)) |-> tmr_r == 8'h00 && pr_r == 8'hff && ctl_r == 7'h00
            && pre_r == 6'h00 && post_r == 4'h0;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("reset values wrong");

    property p_write_clears;
        @(posedge clk) disable iff (!nrst)
        (wr_tmr || wr_ctl) |=> pre_r == 6'h00 && post_r == 4'h0;
    endproperty
    a_write_clears: assert property (p_write_clears)
        else $error("scaler counts not cleared by write");

    property p_flag_cause;
        @(posedge clk) disable iff (!nrst)
        $rose(flag_r) |-> match_r && $past(post_r == ctl_r.postscale_select);
    endproperty
    a_flag_cause: assert property (p_flag_cause)
        else $error("flag set off the postscale count");

    property p_irq_gate;
        @(posedge clk) disable iff (!nrst)
        (flag_r && $past(flag_r) && !en_r) |-> !irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt without enable");

    property p_sleep_hold;
        @(posedge clk) disable iff (!nrst)
        ($past(sleep) && !$past(wr_tmr) && !$past(wr_pr)) |-> $stable(tmr_r) && $stable(pr_r)
            && !match_r;
    endproperty
    a_sleep_hold: assert property (p_sleep_hold)
        else $error("timer moved during sleep");

    property p_off_hold;
        @(posedge clk) disable iff (!nrst)
        ($past(!ctl_r.run_enable) && !$past(wr_tmr) && !$past(wr_ctl))
            |-> $stable(pre_r) && $stable(post_r) && $stable(tmr_r) && !match_r;
    endproperty
    a_off_hold: assert property (p_off_hold)
        else $error("timer moved while off");

    property p_bus_answer;
        @(posedge clk) disable iff (!nrst)
        ((read || write) && waitrequest) |=> !waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus answer late");

    property p_flag_hold;
        @(posedge clk) disable iff (!nrst)
        ($past(nrst) && $past(flag_r) && !$past(wr_sts)) |-> flag_r;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("match flag dropped without a clear");

    property p_post_range;
        @(posedge clk) disable iff (!nrst)
        post_r <= ctl_r.postscale_select;
    endproperty
    a_post_range: assert property (p_post_range)
        else $error("postscaler count beyond its select");

    property p_pr_hold;
        @(posedge clk) disable iff (!nrst)
        ($past(nrst) && !$past(wr_pr)) |-> $stable(pr_r);
    endproperty
    a_pr_hold: assert property (p_pr_hold)
        else $error("period changed without a write");

    property p_pulse_width;
        @(posedge clk) disable iff (!nrst)
        match_r |=> !match_r;
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("match pulse longer than one cycle");

    c_match: cover property (@(posedge clk) disable iff (!nrst) match_r);
    c_flag: cover property (@(posedge clk) disable iff (!nrst) $rose(flag_r) && en_r);
    c_div64: cover property (@(posedge clk) disable iff (!nrst)
        pre_tick && ctl_r.prescale_select == 2'h3);
    c_set_clear: cover property (@(posedge clk) disable iff (!nrst)
        wr_sts && match_ev);
    c_sleep: cover property (@(posedge clk) disable iff (!nrst)
        sleep && instr_ce && ctl_r.run_enable);

endmodule

/* common/period_timer_map.svh */
`ifndef PERIOD_TIMER_MAP_SVH
`define PERIOD_TIMER_MAP_SVH

// Register byte offsets
`define PT_OFS_TICK_COUNTER 5'h00
`define PT_OFS_PERIOD_VALUE 5'h04
`define PT_OFS_TIMER_CONTROL 5'h08
`define PT_OFS_IRQ_STATUS 5'h0c
`define PT_OFS_IRQ_MASK 5'h10

// Field positions
`define PT_CTL_PRESCALE_LSB 0
`define PT_CTL_RUN_BIT 2
`define PT_CTL_POSTSCALE_LSB 3
`define PT_IRQ_MATCH_BIT 0

// Reset values
`define PT_RST_TICK_COUNTER 8'h00
`define PT_RST_PERIOD_VALUE 8'hff
`define PT_RST_TIMER_CONTROL 7'h00

// Timing counts: instruction divider in clk cycles, prescaler in instruction cycles
`define PT_INSTR_DIV_LAST 2'h3
`define PT_PRE_LAST_DIV1 6'h00
`define PT_PRE_LAST_DIV4 6'h03
`define PT_PRE_LAST_DIV16 6'h0f
`define PT_PRE_LAST_DIV64 6'h3f

`endif

/* common/period_timer_pkg.sv */
package period_timer_pkg;

    typedef struct packed {
        logic [3:0] postscale_select;
        logic run_enable;
        logic [1:0] prescale_select;
    } timer_control_t;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } bus_state_t;

endpackage

/* verif/period_timer_test.sv */
`timescale 1ns/1ps
module period_timer_test;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic sleep = 1'b0;
    logic [4:0] address = 5'h00;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] writedata = 32'h0;
    wire logic [31:0] readdata;
    wire logic waitrequest;
    wire logic pwm_time_base;
    wire logic spi_shift_clk;
    wire logic irq;
    int bad_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int pulse_cnt = 0;
    int last_pulse = 0;
    int last_gap = 0;
    logic [31:0] exp_q[$];
    string name_q[$];

    always #25 clk = ~clk;

    period_timer u_dut (
        .clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .sleep(sleep), .pwm_time_base(pwm_time_base),
        .spi_shift_clk(spi_shift_clk), .irq(irq)
    );

    task test_done();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task cmp_val(string what, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task cmp_bit(string what, logic exp, logic got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    // Result watcher: pulses and accepted reads
    always @(posedge clk) begin
        cyc++;
        if (cyc >= 60000) begin
            bad_count++;
            test_done();
        end
        if (pwm_time_base === 1'b1) begin
            last_gap <= cyc - last_pulse;
            last_pulse <= cyc;
            pulse_cnt <= pulse_cnt + 1;
            cmp_bit("spi_shift_clk", 1'b1, spi_shift_clk);
        end
        if (read === 1'b1 && waitrequest === 1'b0)
            cmp_val(name_q.pop_front(), exp_q.pop_front(), readdata);
    end

    task bus_wr(logic [4:0] a, logic [7:0] d);
        @(posedge clk);
        address <= a;
        writedata <= {24'h0, d};
        write <= 1'b1;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        write <= 1'b0;
    endtask

    task bus_rd(logic [4:0] a, logic [31:0] exp, string what);
        exp_q.push_back(exp);
        name_q.push_back(what);
        @(posedge clk);
        address <= a;
        read <= 1'b1;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        read <= 1'b0;
    endtask

    task wait_pulses(int n);
        int s;
        s = pulse_cnt;
        while (pulse_cnt < s + n) @(posedge clk);
    endtask

    task chk_irq(logic e);
        @(posedge clk);
        cmp_bit("irq", e, irq);
    endtask

    task do_reset();
        nrst <= 1'b0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
    endtask

    initial begin
        int p;
        int code;
        int n;
        int k;
        int pc;
        void'($urandom(32597));
        do_reset();
        bus_rd(5'h00, 32'h0, "tick_counter");
        bus_rd(5'h04, 32'hff, "period_value");
        bus_rd(5'h08, 32'h0, "timer_control");
        bus_rd(5'h0c, 32'h0, "status");
        bus_rd(5'h10, 32'h0, "mask");
        bus_rd(5'h14, 32'h0, "unmapped");
        bus_wr(5'h08, 8'hff);
        bus_rd(5'h08, 32'h7f, "timer_control top bit");
        bus_wr(5'h08, 8'h00);
        p = $urandom_range(254, 1);
        bus_wr(5'h04, p[7:0]);
        byteenable <= 4'h0;
        bus_wr(5'h04, ~p[7:0]);
        byteenable <= 4'hf;
        bus_rd(5'h04, p, "period_value");
        bus_wr(5'h00, 8'h5a);
        bus_rd(5'h00, 32'h5a, "tick_counter");
        $display("test registers done");

        for (code = 0; code < 4; code++) begin
            p = $urandom_range(6, 1);
            bus_wr(5'h08, 8'h00);
            bus_wr(5'h04, p[7:0]);
            bus_wr(5'h00, 8'h00);
            bus_wr(5'h08, 8'h04 | code[7:0]);
            wait_pulses(2);
            cmp_val("match gap", (p + 1) * (1 << (2 * code)) * 4, last_gap);
        end
        $display("test prescale done");

        bus_wr(5'h04, 8'h03);
        bus_wr(5'h08, 8'h04);
        sleep <= 1'b1;
        bus_wr(5'h00, 8'h21);
        pc = pulse_cnt;
        repeat (200) @(posedge clk);
        bus_rd(5'h00, 32'h21, "tick_counter asleep");
        bus_rd(5'h04, 32'h03, "period_value asleep");
        cmp_val("pulses asleep", pc, pulse_cnt);
        sleep <= 1'b0;
        bus_wr(5'h08, 8'h00);
        bus_wr(5'h00, 8'h01);
        pc = pulse_cnt;
        repeat (200) @(posedge clk);
        bus_rd(5'h00, 32'h01, "tick_counter stopped");
        cmp_val("pulses stopped", pc, pulse_cnt);
        $display("test hold done");

        // Writes more often than one div64 tick clear the prescaler before it reaches its last count
        bus_wr(5'h04, 8'h00);
        bus_wr(5'h00, 8'h00);
        bus_wr(5'h08, 8'h07);
        pc = pulse_cnt;
        for (k = 0; k < 10; k++) begin
            repeat (150) @(posedge clk);
            if (k % 2 == 1)
                bus_wr(5'h00, 8'h00);
            else
                bus_wr(5'h08, 8'h07);
        end
        cmp_val("pulses with writes", pc, pulse_cnt);
        $display("test prescaler clear done");

        for (k = 0; k < 3; k++) begin
            n = (k == 0) ? 0 : (k == 1) ? 15 : $urandom_range(14, 1);
            bus_wr(5'h08, 8'h00);
            bus_wr(5'h04, 8'h01);
            bus_wr(5'h00, 8'h00);
            bus_wr(5'h0c, 8'h01);
            bus_wr(5'h10, 8'h01);
            pc = pulse_cnt;
            bus_wr(5'h08, {1'b0, n[3:0], 3'b100});
            while (irq !== 1'b1) @(posedge clk);
            @(posedge clk);
            cmp_val("matches per flag", n + 1, pulse_cnt - pc);
        end
        bus_wr(5'h08, 8'h00);
        bus_rd(5'h0c, 32'h1, "status latched");
        bus_wr(5'h10, 8'h00);
        chk_irq(1'b0);
        bus_wr(5'h10, 8'h01);
        chk_irq(1'b1);
        bus_wr(5'h0c, 8'h01);
        chk_irq(1'b0);
        bus_rd(5'h0c, 32'h0, "status cleared");
        $display("test postscale and interrupt done");

        bus_wr(5'h04, 8'h10);
        bus_wr(5'h08, 8'h05);
        do_reset();
        bus_rd(5'h00, 32'h0, "tick_counter after reset");
        bus_rd(5'h04, 32'hff, "period_value after reset");
        bus_rd(5'h08, 32'h0, "timer_control after reset");
        $display("test second reset done");
        test_done();
    end
endmodule
